// *** cad_pkg.sv ***
`default_nettype none
package cad_pkg;

  // ----------------------------------------------------------------
  // Addressing modes
  // ----------------------------------------------------------------
  typedef enum {
    CAD_IMM, CAD_DIR, CAD_EXT, CAD_IX0, CAD_IX1, CAD_IX2,
    CAD_INHA, CAD_INHX, CAD_NONE
  } cad_mode_t;

  // ----------------------------------------------------------------
  // Register/memory functions, low opcode nibble
  // ----------------------------------------------------------------
  localparam logic [3:0] CAD_RM_SUBTRACT = 4'h0;
  localparam logic [3:0] CAD_RM_COMPARE_ACC = 4'h1;
  localparam logic [3:0] CAD_RM_SUB_BORROW = 4'h2;
  localparam logic [3:0] CAD_RM_COMPARE_IDX = 4'h3;
  localparam logic [3:0] CAD_RM_AND = 4'h4;
  localparam logic [3:0] CAD_RM_BIT_TEST = 4'h5;
  localparam logic [3:0] CAD_RM_LOAD_ACC = 4'h6;
  localparam logic [3:0] CAD_RM_STORE_ACC = 4'h7;
  localparam logic [3:0] CAD_RM_XOR = 4'h8;
  localparam logic [3:0] CAD_RM_ADD_CARRY = 4'h9;
  localparam logic [3:0] CAD_RM_OR = 4'ha;
  localparam logic [3:0] CAD_RM_ADD = 4'hb;
  localparam logic [3:0] CAD_RM_JUMP = 4'hc;
  localparam logic [3:0] CAD_RM_JUMP_SUB = 4'hd;
  localparam logic [3:0] CAD_RM_LOAD_IDX = 4'he;
  localparam logic [3:0] CAD_RM_STORE_IDX = 4'hf;

  // ----------------------------------------------------------------
  // Read/modify/write functions, low opcode nibble
  // ----------------------------------------------------------------
  localparam logic [3:0] CAD_RMW_NEGATE = 4'h0;
  localparam logic [3:0] CAD_RMW_COMPLEMENT = 4'h3;
  localparam logic [3:0] CAD_RMW_SHR_LOGIC = 4'h4;
  localparam logic [3:0] CAD_RMW_ROT_RIGHT = 4'h6;
  localparam logic [3:0] CAD_RMW_SHR_ARITH = 4'h7;
  localparam logic [3:0] CAD_RMW_SHL = 4'h8;
  localparam logic [3:0] CAD_RMW_ROT_LEFT = 4'h9;
  localparam logic [3:0] CAD_RMW_DECREMENT = 4'ha;
  localparam logic [3:0] CAD_RMW_INCREMENT = 4'hc;
  localparam logic [3:0] CAD_RMW_TEST_NZ = 4'hd;
  localparam logic [3:0] CAD_RMW_CLEAR = 4'hf;

  localparam logic [7:0] CAD_OP_PRODUCT = 8'h42;

  // ----------------------------------------------------------------
  // Cycle counts and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] CAD_CYC_IMM = 4'h2;
  localparam logic [3:0] CAD_CYC_DIR = 4'h3;
  localparam logic [3:0] CAD_CYC_EXT = 4'h4;
  localparam logic [3:0] CAD_CYC_IX0 = 4'h3;
  localparam logic [3:0] CAD_CYC_IX1 = 4'h4;
  localparam logic [3:0] CAD_CYC_IX2 = 4'h5;
  localparam logic [3:0] CAD_CYC_RMW_INH = 4'h3;
  localparam logic [3:0] CAD_CYC_RMW_DIR = 4'h5;
  localparam logic [3:0] CAD_CYC_RMW_IX1 = 4'h6;
  localparam logic [3:0] CAD_CYC_PRODUCT = 4'hb;
  localparam logic [3:0] CAD_CYC_ILLEGAL = 4'h2;
  localparam logic [3:0] CAD_CYC_STORE_ADD = 4'h1;
  localparam logic [3:0] CAD_CYC_JUMP_SUB = 4'h1;
  localparam logic [3:0] CAD_CYC_CALL_ADD = 4'h2;
  localparam logic [3:0] CAD_CYC_TEST_SUB = 4'h1;
  localparam logic [3:0] CAD_MUL_STEPS = 4'h8;
  localparam logic [5:0] CAD_SP_RESET = 6'h3f;
  localparam logic [9:0] CAD_SP_PAGE = 10'h003;
  localparam logic CAD_I_RESET = 1'b1;

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  function automatic cad_mode_t cad_mode(input logic [7:0] op);
    case (op[7:4])
      4'ha: cad_mode = CAD_IMM;
      4'hb, 4'h3: cad_mode = CAD_DIR;
      4'hc: cad_mode = CAD_EXT;
      4'hd: cad_mode = CAD_IX2;
      4'he, 4'h6: cad_mode = CAD_IX1;
      4'hf, 4'h7: cad_mode = CAD_IX0;
      4'h4: cad_mode = CAD_INHA;
      4'h5: cad_mode = CAD_INHX;
      default: cad_mode = CAD_NONE;
    endcase
  endfunction

  function automatic logic cad_legal(input logic [7:0] op);
    logic [3:0] lo;
    lo = op[3:0];
    if (op == CAD_OP_PRODUCT)
      cad_legal = 1'b1;
    else if (op[7:4] >= 4'ha)
      cad_legal = !(op[7:4] == 4'ha && (lo == CAD_RM_STORE_ACC ||
        lo == CAD_RM_STORE_IDX || lo == CAD_RM_JUMP ||
        lo == CAD_RM_JUMP_SUB));
    else if (op[7:4] >= 4'h3 && op[7:4] <= 4'h7)
      cad_legal = !(lo == 4'h1 || lo == 4'h2 || lo == 4'h5 ||
        lo == 4'hb || lo == 4'he);
    else
      cad_legal = 1'b0;
  endfunction

  function automatic logic [3:0] cad_cycles(input logic [7:0] op);
    logic [3:0] base;
    base = CAD_CYC_ILLEGAL;
    if (!cad_legal(op))
      base = CAD_CYC_ILLEGAL;
    else if (op == CAD_OP_PRODUCT)
      base = CAD_CYC_PRODUCT;
    else if (op[7:4] >= 4'ha) begin
      case (cad_mode(op))
        CAD_IMM: base = CAD_CYC_IMM;
        CAD_DIR: base = CAD_CYC_DIR;
        CAD_EXT: base = CAD_CYC_EXT;
        CAD_IX0: base = CAD_CYC_IX0;
        CAD_IX1: base = CAD_CYC_IX1;
        default: base = CAD_CYC_IX2;
      endcase
      if (op[3:0] == CAD_RM_STORE_ACC || op[3:0] == CAD_RM_STORE_IDX)
        base = base + CAD_CYC_STORE_ADD;
      else if (op[3:0] == CAD_RM_JUMP)
        base = base - CAD_CYC_JUMP_SUB;
      else if (op[3:0] == CAD_RM_JUMP_SUB)
        base = base + CAD_CYC_CALL_ADD;
    end else begin
      case (cad_mode(op))
        CAD_INHA, CAD_INHX: base = CAD_CYC_RMW_INH;
        CAD_IX1: base = CAD_CYC_RMW_IX1;
        default: base = CAD_CYC_RMW_DIR;
      endcase
      if (op[3:0] == CAD_RMW_TEST_NZ && op[7:4] != 4'h4 &&
          op[7:4] != 4'h5)
        base = base - CAD_CYC_TEST_SUB;
    end
    cad_cycles = base;
  endfunction

endpackage
`default_nettype wire

// *** cad_mul8.sv ***
`timescale 1ns/10ps
`default_nettype none
// Shift-add unsigned multiplier, one partial product per clock
module cad_mul8 (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [7:0] mcand,
  input wire logic [7:0] mplier,
  output logic done,
  output logic [15:0] product
);
  logic [15:0] prod_q, prod_d;
  logic [7:0] mcand_q, mcand_d;
  logic [3:0] cnt_q, cnt_d;
  logic done_q, done_d;
  logic [8:0] sum;

  always_comb begin
    prod_d = prod_q;
    mcand_d = mcand_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    sum = {1'b0, prod_q[15:8]} + {1'b0, prod_q[0] ? mcand_q : 8'h00};
    if (start) begin
      prod_d = {8'h00, mplier};
      mcand_d = mcand;
      cnt_d = cad_pkg::CAD_MUL_STEPS;
    end else if (cnt_q != 4'h0) begin
      prod_d = {sum, prod_q[7:1]};
      cnt_d = cnt_q - 4'h1;
      done_d = (cnt_q == 4'h1);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prod_q <= 16'h0000;
      mcand_q <= 8'h00;
      cnt_q <= 4'h0;
      done_q <= 1'b0;
    end else begin
      prod_q <= prod_d;
      mcand_q <= mcand_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign done = done_q;
  assign product = prod_q;
endmodule
`default_nettype wire

// *** cad_core.sv ***
`timescale 1ns/10ps
`default_nettype none
module cad_core #(
  parameter logic [15:0] RESET_PC = 16'h0000
) (
  input wire logic core_clk,
  input wire logic rst,
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  output logic [7:0] acc,
  output logic [7:0] idx,
  output logic [15:0] pc,
  output logic [5:0] sp,
  output logic [4:0] ccr,
  output logic instr_done,
  output logic illegal_op
);
  typedef enum {
    S_FETCH, S_OPND_HI, S_OPND_LO, S_EXEC, S_WRITE,
    S_PUSH_LO, S_PUSH_HI, S_MULT, S_PAD
  } cad_state_t;

  cad_state_t state_q, state_d;
  logic [3:0] cyc_q, cyc_d, total_q, total_d;
  logic [7:0] op_q, op_d, acc_q, acc_d, idx_q, idx_d, wdata_q, wdata_d;
  logic [15:0] pc_q, pc_d, ea_q, ea_d;
  logic [5:0] sp_q, sp_d;
  logic h_q, h_d, n_q, n_d, z_q, z_d, c_q, c_d;
  cad_pkg::cad_mode_t mode;
  logic [3:0] fn;
  logic is_rm, last, mul_start, mul_done;
  logic [15:0] mul_prod;
  logic [7:0] opnd, res;
  logic [8:0] sum9;
  logic nc, nh;

  assign mode = cad_pkg::cad_mode(op_q);
  assign fn = op_q[3:0];
  assign is_rm = (op_q[7:4] >= 4'ha);
  // Padding keeps every opcode at its exact cycle count
  assign last = (cyc_q == total_q - 4'h1);

  cad_mul8 u_mul (
    .core_clk(core_clk),
    .rst(rst),
    .start(mul_start),
    .mcand(idx_q),
    .mplier(acc_q),
    .done(mul_done),
    .product(mul_prod)
  );

  // ----------------------------------------------------------------
  // Arithmetic and logic
  // ----------------------------------------------------------------
  always_comb begin
    case (mode)
      cad_pkg::CAD_INHA: opnd = acc_q;
      cad_pkg::CAD_INHX: opnd = idx_q;
      default: opnd = mem_rdata;
    endcase
    sum9 = 9'h000;
    res = opnd;
    nc = c_q;
    nh = h_q;
    if (is_rm) begin
      case (fn)
        cad_pkg::CAD_RM_SUBTRACT, cad_pkg::CAD_RM_COMPARE_ACC: begin
          sum9 = {1'b0, acc_q} - {1'b0, opnd};
        end
        cad_pkg::CAD_RM_SUB_BORROW: begin
          sum9 = {1'b0, acc_q} - {1'b0, opnd} - {8'h00, c_q};
        end
        cad_pkg::CAD_RM_COMPARE_IDX: begin
          sum9 = {1'b0, idx_q} - {1'b0, opnd};
        end
        cad_pkg::CAD_RM_ADD_CARRY: begin
          sum9 = {1'b0, acc_q} + {1'b0, opnd} + {8'h00, c_q};
        end
        cad_pkg::CAD_RM_ADD: begin
          sum9 = {1'b0, acc_q} + {1'b0, opnd};
        end
        default: sum9 = 9'h000;
      endcase
      case (fn)
        cad_pkg::CAD_RM_AND, cad_pkg::CAD_RM_BIT_TEST: begin
          res = acc_q & opnd;
        end
        cad_pkg::CAD_RM_XOR: res = acc_q ^ opnd;
        cad_pkg::CAD_RM_OR: res = acc_q | opnd;
        cad_pkg::CAD_RM_STORE_ACC: res = acc_q;
        cad_pkg::CAD_RM_STORE_IDX: res = idx_q;
        cad_pkg::CAD_RM_LOAD_ACC, cad_pkg::CAD_RM_LOAD_IDX: res = opnd;
        cad_pkg::CAD_RM_ADD_CARRY, cad_pkg::CAD_RM_ADD: begin
          res = sum9[7:0];
          nc = sum9[8];
          nh = acc_q[4] ^ opnd[4] ^ sum9[4];
        end
        cad_pkg::CAD_RM_JUMP, cad_pkg::CAD_RM_JUMP_SUB: res = opnd;
        default: begin
          res = sum9[7:0];
          nc = sum9[8];
        end
      endcase
    end else begin
      case (fn)
        cad_pkg::CAD_RMW_NEGATE: begin
          res = 8'h00 - opnd;
          nc = |opnd;
        end
        cad_pkg::CAD_RMW_COMPLEMENT: begin
          res = ~opnd;
          nc = 1'b1;
        end
        cad_pkg::CAD_RMW_SHR_LOGIC: {res, nc} = {1'b0, opnd};
        cad_pkg::CAD_RMW_ROT_RIGHT: {res, nc} = {c_q, opnd};
        cad_pkg::CAD_RMW_SHR_ARITH: {res, nc} = {opnd[7], opnd};
        cad_pkg::CAD_RMW_SHL: {nc, res} = {opnd, 1'b0};
        cad_pkg::CAD_RMW_ROT_LEFT: {nc, res} = {opnd, c_q};
        cad_pkg::CAD_RMW_DECREMENT: res = opnd - 8'h01;
        cad_pkg::CAD_RMW_INCREMENT: res = opnd + 8'h01;
        cad_pkg::CAD_RMW_CLEAR: res = 8'h00;
        default: res = opnd;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    cad_state_t fin;
    fin = last ? S_FETCH : S_PAD;
    state_d = state_q;
    cyc_d = cyc_q + 4'h1;
    total_d = total_q;
    op_d = op_q;
    acc_d = acc_q;
    idx_d = idx_q;
    wdata_d = wdata_q;
    pc_d = pc_q;
    ea_d = ea_q;
    sp_d = sp_q;
    h_d = h_q;
    n_d = n_q;
    z_d = z_q;
    c_d = c_q;
    mem_addr = pc_q;
    mem_rd = 1'b0;
    mem_wr = 1'b0;
    mul_start = 1'b0;
    illegal_op = 1'b0;
    case (state_q)
      S_FETCH: begin
        mem_rd = 1'b1;
        op_d = mem_rdata;
        total_d = cad_pkg::cad_cycles(mem_rdata);
        cyc_d = 4'h1;
        pc_d = pc_q + 16'h0001;
        ea_d = {8'h00, idx_q};
        if (!cad_pkg::cad_legal(mem_rdata)) begin
          // Unknown opcodes act as one-byte no-ops
          illegal_op = 1'b1;
          state_d = S_PAD;
        end else if (mem_rdata == cad_pkg::CAD_OP_PRODUCT) begin
          state_d = S_MULT;
        end else begin
          case (cad_pkg::cad_mode(mem_rdata))
            cad_pkg::CAD_IMM: begin
              ea_d = pc_q + 16'h0001;
              pc_d = pc_q + 16'h0002;
              state_d = S_EXEC;
            end
            cad_pkg::CAD_DIR, cad_pkg::CAD_EXT, cad_pkg::CAD_IX1,
            cad_pkg::CAD_IX2: state_d = S_OPND_HI;
            default: state_d = S_EXEC;
          endcase
        end
      end
      S_OPND_HI: begin
        mem_rd = 1'b1;
        pc_d = pc_q + 16'h0001;
        state_d = S_EXEC;
        case (mode)
          cad_pkg::CAD_DIR: ea_d = {8'h00, mem_rdata};
          cad_pkg::CAD_IX1: ea_d = {8'h00, mem_rdata} + {8'h00, idx_q};
          default: begin
            ea_d = {mem_rdata, 8'h00};
            state_d = S_OPND_LO;
          end
        endcase
        // Short jumps take the target with their last operand byte
        if (is_rm && fn == cad_pkg::CAD_RM_JUMP && last) begin
          pc_d = ea_d;
          state_d = fin;
        end
      end
      S_OPND_LO: begin
        mem_rd = 1'b1;
        pc_d = pc_q + 16'h0001;
        ea_d = {ea_q[15:8], mem_rdata} +
          ((mode == cad_pkg::CAD_IX2) ? {8'h00, idx_q} : 16'h0000);
        state_d = S_EXEC;
        if (is_rm && fn == cad_pkg::CAD_RM_JUMP && last) begin
          pc_d = ea_d;
          state_d = fin;
        end
      end
      S_EXEC: begin
        mem_addr = ea_q;
        state_d = fin;
        if (is_rm) begin
          if (fn == cad_pkg::CAD_RM_JUMP) begin
            pc_d = ea_q;
          end else if (fn == cad_pkg::CAD_RM_JUMP_SUB) begin
            wdata_d = pc_q[7:0];
            state_d = S_PUSH_LO;
          end else if (fn == cad_pkg::CAD_RM_STORE_ACC ||
                       fn == cad_pkg::CAD_RM_STORE_IDX) begin
            wdata_d = res;
            n_d = res[7];
            z_d = (res == 8'h00);
            state_d = S_WRITE;
          end else begin
            mem_rd = 1'b1;
            n_d = res[7];
            z_d = (res == 8'h00);
            c_d = nc;
            h_d = nh;
            case (fn)
              cad_pkg::CAD_RM_COMPARE_ACC, cad_pkg::CAD_RM_COMPARE_IDX,
              cad_pkg::CAD_RM_BIT_TEST: acc_d = acc_q;
              cad_pkg::CAD_RM_LOAD_IDX: idx_d = res;
              default: acc_d = res;
            endcase
          end
        end else begin
          mem_rd = (mode != cad_pkg::CAD_INHA && mode != cad_pkg::CAD_INHX);
          n_d = res[7];
          z_d = (res == 8'h00);
          c_d = nc;
          if (fn != cad_pkg::CAD_RMW_TEST_NZ) begin
            case (mode)
              cad_pkg::CAD_INHA: acc_d = res;
              cad_pkg::CAD_INHX: idx_d = res;
              default: begin
                wdata_d = res;
                state_d = S_WRITE;
              end
            endcase
          end
        end
      end
      S_WRITE: begin
        mem_addr = ea_q;
        mem_wr = 1'b1;
        state_d = fin;
      end
      S_PUSH_LO: begin
        mem_addr = {cad_pkg::CAD_SP_PAGE, sp_q};
        mem_wr = 1'b1;
        sp_d = sp_q - 6'h01;
        wdata_d = pc_q[15:8];
        state_d = S_PUSH_HI;
      end
      S_PUSH_HI: begin
        mem_addr = {cad_pkg::CAD_SP_PAGE, sp_q};
        mem_wr = 1'b1;
        sp_d = sp_q - 6'h01; // Wraps within the 64-byte stack page
        pc_d = ea_q;
        state_d = fin;
      end
      S_MULT: begin
        mul_start = (cyc_q == 4'h1);
        if (mul_done) begin
          idx_d = mul_prod[15:8];
          acc_d = mul_prod[7:0];
          h_d = 1'b0;
          c_d = 1'b0;
          state_d = fin;
        end
      end
      S_PAD: state_d = fin;
      default: state_d = S_FETCH;
    endcase
    instr_done = (state_q != S_FETCH) && (state_d == S_FETCH);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= S_FETCH;
      cyc_q <= 4'h0;
      total_q <= cad_pkg::CAD_CYC_ILLEGAL;
      op_q <= 8'h00;
      acc_q <= 8'h00;
      idx_q <= 8'h00;
      wdata_q <= 8'h00;
      pc_q <= RESET_PC;
      ea_q <= 16'h0000;
      sp_q <= cad_pkg::CAD_SP_RESET;
      h_q <= 1'b0;
      n_q <= 1'b0;
      z_q <= 1'b0;
      c_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cyc_q <= cyc_d;
      total_q <= total_d;
      op_q <= op_d;
      acc_q <= acc_d;
      idx_q <= idx_d;
      wdata_q <= wdata_d;
      pc_q <= pc_d;
      ea_q <= ea_d;
      sp_q <= sp_d;
      h_q <= h_d;
      n_q <= n_d;
      z_q <= z_d;
      c_q <= c_d;
    end
  end

  assign mem_wdata = wdata_q;
  assign acc = acc_q;
  assign idx = idx_q;
  assign pc = pc_q;
  assign sp = sp_q;
  assign ccr = {h_q, cad_pkg::CAD_I_RESET, n_q, z_q, c_q};
endmodule
`default_nettype wire

// *** cad_mem_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module cad_mem_model (
  input wire logic core_clk,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q;

  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    last_q = 8'h00;
  end

  // ----------------------------------------------------------------
  // Asynchronous read, write at the edge
  // ----------------------------------------------------------------
  // Idle cycles show a byte that flips, so stale data never passes
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_q;

  always @(posedge core_clk) begin
    last_q <= mem_rdata;
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
endmodule
`default_nettype wire

// *** cad_core_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module cad_core_assertions (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic [7:0] acc,
  input wire logic [7:0] idx,
  input wire logic [15:0] pc,
  input wire logic [5:0] sp,
  input wire logic [4:0] ccr,
  input wire logic instr_done,
  input wire logic illegal_op
);
  logic first_q;

  // Cycle after reset or after a finished instruction is a fetch
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      first_q <= 1'b1;
    end else begin
      first_q <= instr_done;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  chk_one_access: assert property (!(mem_rd && mem_wr))
    else $error("read and write in one cycle");
  chk_product_time: assert property (
    first_q && mem_rd && mem_rdata == 8'h42 |->
      ##1 (!instr_done) [*8] ##1 !instr_done ##1 instr_done)
    else $error("product not done in eleven cycles");
  chk_product_bytes: assert property (
    first_q && mem_rd && mem_rdata == 8'h42 |-> ##11
      {idx, acc} == {8'h00, $past(idx, 11)} * {8'h00, $past(acc, 11)})
    else $error("product bytes wrong");
  chk_test_no_write: assert property (
    first_q && mem_rd && mem_rdata inside {8'h3d, 8'h7d, 8'h6d, 8'h4d}
      |-> (!mem_wr) [*4])
    else $error("negative or zero test wrote");
  chk_modify_back: assert property (
    first_q && mem_rd && mem_rdata == 8'h3c |-> ##3 mem_wr &&
      mem_addr == {8'h00, $past(mem_rdata, 2)} &&
      mem_wdata == $past(mem_rdata, 1) + 8'h01 ##1 instr_done)
    else $error("increment not written back");
  chk_direct_time: assert property (
    first_q && mem_rd && mem_rdata inside {8'hb9, 8'hb2, 8'hb8, 8'hb1,
      8'hb3, 8'hb5} |-> !instr_done ##1 !instr_done ##1 instr_done)
    else $error("direct operation not three cycles");
  chk_acc_compare_kept: assert property (
    first_q && mem_rd && mem_rdata[3:0] == 4'h1 && mem_rdata[7:4] >= 4'ha
      |-> ##3 acc == $past(acc, 3))
    else $error("compare changed accumulator");
  chk_idx_compare_kept: assert property (
    first_q && mem_rd && mem_rdata[3:0] == 4'h3 && mem_rdata[7:4] >= 4'ha
      |-> ##3 idx == $past(idx, 3))
    else $error("index compare changed index");
  chk_bit_keeps_acc: assert property (
    first_q && mem_rd && mem_rdata[3:0] == 4'h5 && mem_rdata[7:4] >= 4'ha
      |-> ##3 acc == $past(acc, 3))
    else $error("bit test changed accumulator");
  chk_store_direct: assert property (
    first_q && mem_rd && mem_rdata == 8'hb7 |-> ##3 mem_wr && instr_done &&
      mem_addr == {8'h00, $past(mem_rdata, 2)} && mem_wdata == acc)
    else $error("direct store wrong");
  chk_jump_target: assert property (
    first_q && mem_rd && mem_rdata == 8'hcc |->
      ##3 pc == {$past(mem_rdata, 2), $past(mem_rdata, 1)})
    else $error("jump target wrong");
  chk_call_push: assert property (
    first_q && mem_rd && mem_rdata == 8'hcd |->
      ##4 mem_wr && mem_addr == {10'h003, sp} ##1 mem_wr && instr_done &&
      mem_addr == $past(mem_addr) - 16'h0001)
    else $error("call push wrong");
  chk_no_store_imm: assert property (
    first_q && mem_rd && mem_rdata == 8'ha7 |-> illegal_op && !mem_wr
      ##1 !mem_wr && instr_done)
    else $error("store with immediate operand not refused");
endmodule

bind cad_core cad_core_assertions u_cad_core_assertions (
  .core_clk(core_clk), .rst(rst), .mem_addr(mem_addr), .mem_rd(mem_rd),
  .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
  .acc(acc), .idx(idx), .pc(pc), .sp(sp), .ccr(ccr),
  .instr_done(instr_done), .illegal_op(illegal_op));
`default_nettype wire

// *** cad_core_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module cad_core_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] mem_addr, pc, pcm, ea;
  logic mem_rd, mem_wr, instr_done, illegal_op, cin;
  logic [7:0] mem_wdata, mem_rdata, acc, idx, x_m, op, a, m, exp8, got;
  logic [5:0] sp;
  logic [4:0] ccr;
  int n_errors = 0;
  int n_checks = 0;
  int seed = 79471;
  int cyc;
  logic [3:0] cols [6] = '{4'ha, 4'hb, 4'hc, 4'hf, 4'he, 4'hd};
  logic [3:0] fns [6] = '{4'h9, 4'h2, 4'h8, 4'h1, 4'h3, 4'h5};
  logic [7:0] rmw_op [9] = '{8'h4c, 8'h5c, 8'h3c, 8'h7c, 8'h6c, 8'h4d,
    8'h3d, 8'h7d, 8'h6d};
  int rmw_cyc [9] = '{3, 3, 5, 5, 6, 3, 4, 4, 5};

  always #5 core_clk = ~core_clk;

  cad_core #(.RESET_PC(16'h1000)) u_cad_core (
    .core_clk(core_clk), .rst(rst), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .acc(acc), .idx(idx), .pc(pc), .sp(sp), .ccr(ccr),
    .instr_done(instr_done), .illegal_op(illegal_op));
  cad_mem_model u_cad_mem_model (
    .core_clk(core_clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  // ----------------------------------------------------------------
  // Checking and program helpers
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("Checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e,
      input string what);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask

  task automatic chk16(input logic [15:0] g, input logic [15:0] e,
      input string what);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask

  task automatic put(input logic [7:0] b);
    u_cad_mem_model.mem[pcm] = b;
    pcm = pcm + 16'h0001;
  endtask

  function automatic logic [15:0] ea_of(input logic [3:0] hi,
      input logic [5:0] r);
    case (hi)
      4'hb, 4'h3: ea_of = 16'h0040 + r;
      4'hc: ea_of = 16'h2000 + r;
      4'hf, 4'h7: ea_of = {8'h00, x_m};
      4'he, 4'h6: ea_of = 16'h0040 + x_m;
      default: ea_of = 16'h2000 + x_m;
    endcase
  endfunction

  function automatic int mcyc(input logic [7:0] o);
    int c;
    case (o[7:4])
      4'ha: c = 2;
      4'hb, 4'hf: c = 3;
      4'hc, 4'he: c = 4;
      default: c = 5;
    endcase
    if (o[3:0] == 4'h7 || o[3:0] == 4'hf)
      c = c + 1;
    return c;
  endfunction

  // Entered at a falling edge in the fetch cycle of the instruction
  task automatic exec(input logic [7:0] o, input logic [15:0] e,
      input logic [7:0] imm, output int n);
    logic [15:0] off;
    off = e - {8'h00, x_m};
    put(o);
    case (o[7:4])
      4'ha: put(imm);
      4'hb, 4'h3: put(e[7:0]);
      4'hc: begin
        put(e[15:8]);
        put(e[7:0]);
      end
      4'he, 4'h6: put(off[7:0]);
      4'hd: begin
        put(off[15:8]);
        put(off[7:0]);
      end
      default: ;
    endcase
    n = 1;
    while (instr_done !== 1'b1) begin
      @(negedge core_clk);
      n++;
      if (n > 20) begin
        n_errors++;
        $display("Error at %0t: instruction never completed", $time);
        end_of_test();
      end
    end
    @(negedge core_clk);
  endtask

  task automatic ld(input logic [7:0] o, input logic [7:0] v);
    int c;
    exec(o, 16'h0000, v, c);
    if (o == 8'hae)
      x_m = v;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    pcm = 16'h1000;
    x_m = 8'h00;
    chk16(pc, 16'h1000, "reset pc");
    chk8({2'b00, sp}, 8'h3f, "reset sp");
    chk8({3'b000, ccr}, 8'h08, "reset flags");
    for (int i = 0; i < 72; i++) begin
      op = {cols[i % 6], fns[(i / 6) % 6]};
      a = (i % 7 == 0) ? 8'hff : 8'($random(seed));
      m = (i % 5 == 0) ? 8'hff : 8'($random(seed));
      ld(8'ha6, a);
      ld(8'hae, 8'($random(seed)));
      exp8 = 8'($random(seed));
      cin = a < exp8;
      ld(8'ha1, exp8);
      ea = ea_of(op[7:4], 6'($random(seed)));
      u_cad_mem_model.mem[ea] = m;
      exec(op, ea, m, cyc);
      case (op[3:0])
        4'h9: exp8 = a + m + cin;
        4'h2: exp8 = a - m - cin;
        4'h8: exp8 = a ^ m;
        default: exp8 = a;
      endcase
      chk8(acc, exp8, "accumulator");
      chk8(idx, x_m, "index kept");
      chk8(u_cad_mem_model.mem[ea], m, "operand kept");
      chk8(8'(cyc), 8'(mcyc(op)), "cycles");
      chk16(pc, pcm, "length");
      exp8 = (op[3:0] == 4'h3) ? x_m : a;
      got = {6'h00, ccr[1:0]};
      if (op[3:0] == 4'h1 || op[3:0] == 4'h3)
        chk8(got, {6'h00, exp8 == m, exp8 < m}, "flag");
      if (op[3:0] == 4'h5)
        chk8(got, {6'h00, (a & m) == 8'h00, cin}, "bit");
    end
    for (int i = 0; i < 10; i++) begin
      op = {cols[1 + i % 5], (i < 5) ? 4'h7 : 4'hf};
      a = 8'($random(seed));
      ld(8'ha6, a);
      ld(8'hae, 8'($random(seed)));
      ea = ea_of(op[7:4], 6'($random(seed)));
      exec(op, ea, 8'h00, cyc);
      chk8(u_cad_mem_model.mem[ea], op[3] ? x_m : a, "stored");
      chk8(8'(cyc), 8'(mcyc(op)), "store cycles");
    end
    for (int i = 0; i < 9; i++) begin
      op = rmw_op[i];
      a = 8'($random(seed));
      m = (i == 2) ? 8'hff : 8'($random(seed));
      ld(8'ha6, a);
      ld(8'hae, 8'($random(seed)));
      ea = ea_of(op[7:4], 6'($random(seed)));
      u_cad_mem_model.mem[ea] = m;
      exec(op, ea, 8'h00, cyc);
      exp8 = (op[7:4] == 4'h4) ? a : (op[7:4] == 4'h5) ? x_m : m;
      if (op[3:0] == 4'hc)
        exp8 = exp8 + 8'h01;
      got = (op[7:4] == 4'h4) ? acc : (op[7:4] == 4'h5) ? idx :
        u_cad_mem_model.mem[ea];
      chk8(got, exp8, "modified operand");
      chk8(8'(cyc), 8'(rmw_cyc[i]), "modify cycles");
      chk16(pc, pcm, "modify length");
    end
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 8'hff : 8'($random(seed));
      m = (i == 0) ? 8'hff : 8'($random(seed));
      ld(8'ha6, a);
      ld(8'hae, m);
      exec(8'h42, 16'h0000, 8'h00, cyc);
      ea = {8'h00, a} * {8'h00, m};
      chk16({idx, acc}, ea, "product");
      chk8(8'(cyc), 8'h0b, "product cycles");
      chk8({6'h00, ccr[4], ccr[0]}, 8'h00, "product flags");
    end
    // Store with an immediate operand is refused as a one-byte no-op
    exec(8'ha7, 16'h0000, 8'h9d, cyc);
    pcm = pcm - 16'h0001;
    chk16(pc, pcm, "store immediate length");
    chk8(8'(cyc), 8'h02, "store immediate cycles");
    exec(8'hcc, 16'h3000, 8'h00, cyc);
    chk16(pc, 16'h3000, "jump target");
    chk8(8'(cyc), 8'h03, "jump cycles");
    pcm = 16'h3000;
    exec(8'hcd, 16'h3100, 8'h00, cyc);
    chk16(pc, 16'h3100, "call target");
    chk8(8'(cyc), 8'h06, "call cycles");
    pcm = {u_cad_mem_model.mem[16'h00fe], u_cad_mem_model.mem[16'h00ff]};
    chk16(pcm, 16'h3003, "return address");
    chk8({2'b00, sp}, 8'h3d, "stack pointer");
    end_of_test();
  end
endmodule
`default_nettype wire
